//--- hdl/sdiio_regs.svh
`ifndef SDIIO_REGS_SVH
`define SDIIO_REGS_SVH
`define SDIIO_LVL_L       2'h0
`define SDIIO_LVL_R       2'h1
`define SDIIO_LVL_F       2'h2
`define SDIIO_LVL_H       2'h3
`define SDIIO_TH_LR       8'h33
`define SDIIO_TH_RF       8'h80
`define SDIIO_TH_FH       8'hcc
`define SDIIO_BOOST_H     8'h00
`define SDIIO_BOOST_F     8'h00
`define SDIIO_BOOST_R     8'h80
`define SDIIO_BOOST_L     8'h90
`define SDIIO_ADAPT_N     16
`define SDIIO_RST_NS      100
`define SDIIO_RST_CYC     ((`SDIIO_RST_NS + 9) / 10)
`endif

//--- hdl/sdiio_pkg.sv
package sdiio_pkg;
	typedef enum logic [1:0] {
		SDIIO_OFF  = 2'b00,
		SDIIO_SAVE = 2'b01,
		SDIIO_RUN  = 2'b11
	} sdiio_pwr_t;
	typedef enum logic [2:0] {
		SDIIO_R3G   = 3'h0,
		SDIIO_R3GM  = 3'h1,
		SDIIO_RHD   = 3'h2,
		SDIIO_RHDM  = 3'h3,
		SDIIO_RSD   = 3'h4,
		SDIIO_R125  = 3'h5,
		SDIIO_RNONE = 3'h6
	} sdiio_rate_t;
	typedef struct packed {
		logic       adaptive;
		logic [7:0] boost;
		logic [1:0] out_level;
	} sdiio_heq_t;
endpackage

//--- hdl/sdiio_cfg_if.sv
`timescale 1ns/1ps
interface sdiio_cfg_if;
	import sdiio_pkg::*;
	logic [1:0] level;
	sdiio_heq_t heq;
	logic       scan_go;
	logic [3:0] scan_idx;
	logic       scan_done;
	modport dec (input level, output heq);
	modport top (output level, input heq, output scan_go,
		input scan_idx, input scan_done);
	modport scan (input scan_go, output scan_idx, output scan_done);
endinterface

//--- hdl/sdiio_heq_dec.sv
`timescale 1ns/1ps
`include "sdiio_regs.svh"
module sdiio_heq_dec (
	sdiio_cfg_if.dec                 cfg,
	input  wire logic                i_rate3g
);
	import sdiio_pkg::*;
	// ******************************
	// Host eq strap decode
	// ******************************
	always_comb begin
		cfg.heq.out_level = cfg.level;
		cfg.heq.adaptive  = 1'b0;
		case (cfg.level)
			`SDIIO_LVL_H: cfg.heq.boost = `SDIIO_BOOST_H;
			`SDIIO_LVL_F: begin
				cfg.heq.boost    = `SDIIO_BOOST_F;
				cfg.heq.adaptive = i_rate3g;
			end
			`SDIIO_LVL_R: cfg.heq.boost = `SDIIO_BOOST_R;
			default:      cfg.heq.boost = `SDIIO_BOOST_L;
		endcase
	end
endmodule

//--- hdl/sdiio_top.sv
`timescale 1ns/1ps
`include "sdiio_regs.svh"
module sdiio_top #(
	parameter int N_SET = `SDIIO_ADAPT_N
) (
	input  wire logic                 i_clk_sys,
	input  wire logic                 i_rstn,
	input  wire logic                 i_enable,
	input  wire logic                 i_direction_select,
	input  wire logic                 i_host_loopback_select,
	input  wire logic                 i_loopthru_select,
	input  wire logic [7:0]           i_host_eq_strap_v,
	input  wire logic                 i_line_sig,
	input  wire logic                 i_host_sig,
	input  wire logic [2:0]           i_rate,
	input  wire logic                 i_lock_pin_cd,
	input  wire logic                 i_splitter_mode,
	input  wire logic                 i_heq_ovr,
	input  wire logic                 i_heq_ovr_adapt,
	input  wire logic [7:0]           i_heq_ovr_boost,
	input  wire logic [7:0]           i_adapt_score,
	output logic                      o_line_eq_en,
	output logic                      o_line_drv_en,
	output logic                      o_host_eq_en,
	output logic                      o_host_out_en,
	output logic                      o_line_aux_output_en,
	output logic                      o_cdr_reset,
	output logic                      o_reclock_en,
	output logic                      o_half_amp,
	output logic                      o_line_adapt_run,
	output logic                      o_detect_en,
	output logic                      o_signal_status,
	output logic                      o_lock_n,
	output sdiio_pkg::sdiio_pwr_t     o_power,
	output logic                      o_heq_adaptive,
	output logic [7:0]                o_heq_boost,
	output logic [1:0]                o_host_out_level,
	output logic [3:0]                o_adapt_pick
);
	import sdiio_pkg::*;

	// ******************************
	// Reset release and pin sync
	// ******************************
	logic       rst_a;
	logic       rstn;
	logic [6:0] s1;
	logic [6:0] s2;
	logic [7:0] lv1;
	logic [7:0] lv2;
	logic [7:0] lv3;
	logic [7:0] lvs;
	logic [7:0] next_lvs;
	// A strap word is taken only once two samples agree, so bits caught
	// mid-change cannot select a wrong level
	assign next_lvs = (lv2 == lv3) ? lv2 : lvs;
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			rst_a <= 1'b0;
			rstn  <= 1'b0;
		end else begin
			rst_a <= 1'b1;
			rstn  <= rst_a;
		end
	end
	always_ff @(posedge i_clk_sys or negedge rstn) begin
		if (!rstn) begin
			s1  <= 7'h00;
			s2  <= 7'h00;
			lv1 <= 8'h00;
			lv2 <= 8'h00;
			lv3 <= 8'h00;
			lvs <= 8'h00;
		end else begin
			s1  <= {i_enable, i_direction_select, i_host_loopback_select,
				i_loopthru_select, i_line_sig, i_host_sig, i_lock_pin_cd};
			s2  <= s1;
			lv1 <= i_host_eq_strap_v;
			lv2 <= lv1;
			lv3 <= lv2;
			lvs <= next_lvs;
		end
	end
	logic en_s;
	logic dir_s;
	logic hlb_s;
	logic lt_s;
	logic line_s;
	logic host_s;
	logic lockcd_s;
	assign {en_s, dir_s, hlb_s, lt_s, line_s, host_s, lockcd_s} = s2;

	// ******************************
	// Four-level strap slicer
	// ******************************
	logic [1:0] level;
	always_comb begin
		if (lvs >= `SDIIO_TH_FH)
			level = `SDIIO_LVL_H;
		else if (lvs >= `SDIIO_TH_RF)
			level = `SDIIO_LVL_F;
		else if (lvs >= `SDIIO_TH_LR)
			level = `SDIIO_LVL_R;
		else
			level = `SDIIO_LVL_L;
	end

	sdiio_cfg_if cfg ();
	assign cfg.level = level;
	logic rate3g;
	assign rate3g = (i_rate == SDIIO_R3G) || (i_rate == SDIIO_R3GM);
	sdiio_heq_dec u_dec (
		.cfg      (cfg),
		.i_rate3g (rate3g)
	);

	// ******************************
	// Direction tracking, power state
	// ******************************
	// Direction is caught after reset release; later edges retrigger CDR.
	// The warm-up waits for the synchroniser to hold a real pin sample,
	// so a strap tied high does not look like a change after reset.
	logic       dir_q;
	logic       dir_valid;
	logic [1:0] warm;
	logic [3:0] rst_cnt;
	logic       next_dir_q;
	logic       next_dir_valid;
	logic [1:0] next_warm;
	logic [3:0] next_rst_cnt;
	sdiio_pwr_t pwr;
	sdiio_pwr_t next_pwr;
	logic       sig;
	assign sig = dir_s ? host_s : line_s;
	always_comb begin
		next_dir_q     = dir_s;
		next_dir_valid = warm[1];
		next_warm      = {warm[0], 1'b1};
		next_rst_cnt   = rst_cnt;
		if (dir_valid && dir_s != dir_q)
			next_rst_cnt = 4'(`SDIIO_RST_CYC);
		else if (rst_cnt != 4'h0)
			next_rst_cnt = rst_cnt - 4'h1;
		if (!en_s)
			next_pwr = SDIIO_OFF;
		else if (sig)
			next_pwr = SDIIO_RUN;
		else
			next_pwr = SDIIO_SAVE;
	end
	always_ff @(posedge i_clk_sys or negedge rstn) begin
		if (!rstn) begin
			dir_q     <= 1'b0;
			dir_valid <= 1'b0;
			warm      <= 2'h0;
			rst_cnt   <= 4'h0;
			pwr       <= SDIIO_OFF;
		end else begin
			dir_q     <= next_dir_q;
			dir_valid <= next_dir_valid;
			warm      <= next_warm;
			rst_cnt   <= next_rst_cnt;
			pwr       <= next_pwr;
		end
	end

	// ******************************
	// Adaptive boost scan
	// ******************************
	// One sweep per run; afterwards the pick rests on the best preset so
	// the equalizer is not disturbed by further trials
	logic       scanning;
	logic [3:0] best;
	logic [7:0] best_sc;
	logic       try_v;
	logic [3:0] next_best;
	logic [7:0] next_best_sc;
	logic       next_try_v;
	logic [3:0] next_pick;
	sdiio_heq_scan #(
		.N_SET (N_SET)
	) u_scan (
		.i_clk_sys (i_clk_sys),
		.i_rstn    (rstn),
		.cfg       (cfg)
	);
	always_comb begin
		next_best    = best;
		next_best_sc = best_sc;
		// The score seen now belongs to the preset applied last cycle
		if (try_v && (o_adapt_pick == 4'h0 || i_adapt_score > best_sc)) begin
			next_best    = o_adapt_pick;
			next_best_sc = i_adapt_score;
		end
		next_try_v = scanning && !cfg.scan_done;
		next_pick  = next_try_v ? cfg.scan_idx : next_best;
	end
	always_ff @(posedge i_clk_sys or negedge rstn) begin
		if (!rstn) begin
			best    <= 4'h0;
			best_sc <= 8'h00;
			try_v   <= 1'b0;
		end else begin
			best    <= next_best;
			best_sc <= next_best_sc;
			try_v   <= next_try_v;
		end
	end

	// ******************************
	// Output steering
	// ******************************
	logic       rx;
	logic       run;
	logic       heq_ad;
	logic [7:0] heq_bst;
	assign rx  = !dir_s;
	assign run = (pwr == SDIIO_RUN);
	always_comb begin
		// Override wins over the strap for as long as it is held
		heq_ad  = i_heq_ovr ? i_heq_ovr_adapt : cfg.heq.adaptive;
		heq_bst = i_heq_ovr ? i_heq_ovr_boost : cfg.heq.boost;
	end
	assign scanning = run && !rx && heq_ad;
	assign cfg.scan_go = scanning;

	logic [22:0] nq;
	logic [22:0] q;
	// Power is staged with the enables so both change on one edge
	sdiio_pwr_t  pwr_q;
	always_comb begin
		nq = 23'h0;
		nq[0]  = run && rx;
		nq[1]  = run && !rx;
		nq[2]  = run && !rx;
		nq[3]  = run && (rx || !hlb_s);
		nq[4]  = run && !lt_s;
		nq[5]  = (rst_cnt != 4'h0);
		nq[6]  = run && (i_rate != SDIIO_R125)
			&& (i_rate != SDIIO_RNONE);
		nq[7]  = rx && i_splitter_mode;
		nq[8]  = run && rx;
		nq[9]  = (pwr != SDIIO_OFF);
		nq[10] = en_s && sig;
		nq[11] = lockcd_s ? !(en_s && sig) : 1'b1;
		nq[12] = !rx && heq_ad;
		nq[20:13] = rx ? 8'h00 : heq_bst;
		nq[22:21] = cfg.heq.out_level;
	end
	always_ff @(posedge i_clk_sys or negedge rstn) begin
		if (!rstn) begin
			q            <= 23'h000800;
			o_adapt_pick <= 4'h0;
			pwr_q        <= SDIIO_OFF;
		end else begin
			q            <= nq;
			o_adapt_pick <= next_pick;
			pwr_q        <= pwr;
		end
	end
	assign o_line_eq_en         = q[0];
	assign o_line_drv_en        = q[1];
	assign o_host_eq_en         = q[2];
	assign o_host_out_en        = q[3];
	assign o_line_aux_output_en = q[4];
	assign o_cdr_reset          = q[5];
	assign o_reclock_en         = q[6];
	assign o_half_amp           = q[7];
	assign o_line_adapt_run     = q[8];
	assign o_detect_en          = q[9];
	assign o_signal_status      = q[10];
	assign o_lock_n             = q[11];
	assign o_heq_adaptive       = q[12];
	assign o_heq_boost          = q[20:13];
	assign o_host_out_level     = q[22:21];
	assign o_power              = pwr_q;
endmodule

// ******************************
// Preset sweep sequencer
// ******************************
module sdiio_heq_scan #(
	parameter int N_SET = `SDIIO_ADAPT_N
) (
	input  wire logic  i_clk_sys,
	input  wire logic  i_rstn,
	sdiio_cfg_if.scan  cfg
);
	import sdiio_pkg::*;
	logic [3:0] idx;
	logic       done;
	logic [3:0] next_idx;
	logic       next_done;
	always_comb begin
		next_idx  = idx;
		next_done = done;
		if (!cfg.scan_go) begin
			next_idx  = 4'h0;
			next_done = 1'b0;
		end else if (!done) begin
			if (idx == 4'(N_SET - 1))
				next_done = 1'b1;
			else
				next_idx = idx + 4'h1;
		end
	end
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			idx  <= 4'h0;
			done <= 1'b0;
		end else begin
			idx  <= next_idx;
			done <= next_done;
		end
	end
	assign cfg.scan_idx  = idx;
	assign cfg.scan_done = done;
endmodule

//--- sim/sdiio_far_model.sv
`timescale 1ns/1ps
// ************************************************
// Far side: cable and host device
// ************************************************
module sdiio_far_model #(
	parameter logic [3:0] PEAK = 4'h5
) (
	input  wire logic       i_line_on,
	input  wire logic       i_host_on,
	input  wire logic [2:0] i_rate_code,
	input  wire logic [3:0] i_pick,
	output logic            o_line_sig,
	output logic            o_host_sig,
	output logic [2:0]      o_rate,
	output logic [7:0]      o_score
);
	assign o_line_sig = i_line_on;
	assign o_host_sig = i_host_on;
	assign o_rate     = i_rate_code;
	// One clear best setting, so a wrong pick cannot pass
	assign o_score = (i_pick == PEAK) ? 8'hf0 : {4'h0, i_pick};
endmodule

//--- sim/sdiio_top_checker.sv
`timescale 1ns/1ps
module sdiio_top_checker #(
	parameter int N_SET = 16
) (
	input  wire logic              i_clk_sys,
	input  wire logic              i_rstn,
	input  wire logic              i_enable,
	input  wire logic              i_lock_pin_cd,
	input  wire logic [2:0]        i_rate,
	input  wire logic              o_line_eq_en,
	input  wire logic              o_line_drv_en,
	input  wire logic              o_host_eq_en,
	input  wire logic              o_host_out_en,
	input  wire logic              o_line_aux_output_en,
	input  wire logic              o_cdr_reset,
	input  wire logic              o_reclock_en,
	input  wire logic              o_lock_n,
	input  sdiio_pkg::sdiio_pwr_t  o_power,
	input  wire logic [7:0]        o_heq_boost
);
	import sdiio_pkg::*;
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_rstn);
	chk_dir_excl: assert property (!(o_line_drv_en && o_line_eq_en))
		else $error("line driver and line eq both on");
	chk_host_eq_rx: assert property (o_line_eq_en |->
		!o_host_eq_en && o_heq_boost == 8'h00)
		else $error("host eq active in receive");
	chk_off_quiet: assert property (o_power == SDIIO_OFF |-> !o_line_eq_en
		&& !o_line_drv_en && !o_host_out_en && !o_line_aux_output_en)
		else $error("path enabled while off");
	chk_off_cause: assert property (!i_enable [*5] |-> o_power == SDIIO_OFF)
		else $error("enable low did not power down");
	chk_rx_host_on: assert property (o_power == SDIIO_RUN && o_line_eq_en
		|-> o_host_out_en)
		else $error("host output off in receive");
	chk_cdr_pulse: assert property ($rose(o_cdr_reset) |->
		o_cdr_reset [*8] ##1 o_cdr_reset ##1 o_cdr_reset
		##1 !o_cdr_reset)
		else $error("recovery reset pulse length wrong");
	chk_lock_idle: assert property (!i_lock_pin_cd [*5] |-> o_lock_n)
		else $error("lock pin asserted without selection");
	chk_slow_bypass: assert property ((i_rate == 3'h5) [*5] |-> !o_reclock_en)
		else $error("reclocker kept at slow rate");
	cover property ($rose(o_cdr_reset));
	cover property (o_power == SDIIO_SAVE);
	cover property (o_line_drv_en && o_line_aux_output_en);
endmodule
bind sdiio_top sdiio_top_checker #(.N_SET(N_SET)) u_chk (.*);

//--- sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	import sdiio_pkg::*;
	logic i_clk_sys = 0, i_rstn = 0, i_enable = 0, i_direction_select = 0;
	logic i_host_loopback_select = 1, i_loopthru_select = 1;
	logic i_lock_pin_cd = 0, i_splitter_mode = 1, i_heq_ovr = 0;
	logic i_heq_ovr_adapt = 0, i_line_sig, i_host_sig, line_on = 0, host_on = 0;
	logic [7:0] i_host_eq_strap_v = 8'hb0, i_heq_ovr_boost = 8'h00, i_adapt_score;
	logic [2:0] i_rate, rate_code = 3'h0;
	logic o_line_eq_en, o_line_drv_en, o_host_eq_en, o_host_out_en, o_cdr_reset;
	logic o_line_aux_output_en, o_reclock_en, o_half_amp, o_line_adapt_run;
	logic o_detect_en, o_signal_status, o_lock_n, o_heq_adaptive;
	logic [7:0] o_heq_boost;
	logic [1:0] o_host_out_level;
	logic [3:0] o_adapt_pick;
	sdiio_pwr_t o_power;
	int err_total = 0, check_count = 0, n;
	logic [7:0] sv[4] = '{8'hff, 8'hb0, 8'h60, 8'h10};
	logic [7:0] bs[4] = '{8'h00, 8'h00, 8'h80, 8'h90};
	sdiio_top u_dut (.*);
	sdiio_far_model u_far (.i_line_on(line_on), .i_host_on(host_on),
		.i_rate_code(rate_code), .i_pick(o_adapt_pick), .o_line_sig(i_line_sig),
		.o_host_sig(i_host_sig), .o_rate(i_rate), .o_score(i_adapt_score));
	always #5 i_clk_sys = ~i_clk_sys;
	task automatic chk(input logic [7:0] got, input logic [7:0] exp,
		input string m);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %0t %s", $time, m);
		end
	endtask
	// Outputs settle within five edges of a pin change; eight leave margin
	task automatic setp(input logic en, dir, lb, lt, ls, hs);
		@(posedge i_clk_sys);
		i_enable <= en;
		i_direction_select <= dir;
		i_host_loopback_select <= lb;
		i_loopthru_select <= lt;
		line_on <= ls;
		host_on <= hs;
		repeat (8) @(posedge i_clk_sys);
		// Compare at the falling edge, well away from any update
		@(negedge i_clk_sys);
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		#500000;
		err_total++;
		give_verdict();
	end
	initial begin
		repeat (20) @(posedge i_clk_sys);
		i_rstn <= 1;
		for (int k = 0; k < 4; k++) begin
			setp(1, 0, k[1], k[0], 1, 0);
			chk(o_line_eq_en, 1, "rx eq");
			chk(o_line_drv_en, 0, "rx driver");
			chk(o_host_out_en, 1, "rx host out");
			chk(o_line_aux_output_en, !k[0], "rx aux");
			chk(o_host_eq_en, 0, "rx host eq");
			chk(o_half_amp, 1, "splitter");
			chk(o_line_adapt_run, 1, "line adapt");
		end
		$display("receive test done");
		n = 0;
		@(posedge i_clk_sys);
		i_direction_select <= 1;
		line_on <= 0;
		host_on <= 1;
		repeat (30) begin
			@(negedge i_clk_sys);
			n += o_cdr_reset;
		end
		chk(n, 10, "relock pulse");
		for (int k = 0; k < 4; k++) begin
			setp(1, 1, k[1], k[0], 0, 1);
			chk(o_line_drv_en, 1, "tx driver");
			chk(o_line_eq_en, 0, "tx eq");
			chk(o_host_out_en, !k[1], "tx loopback");
			chk(o_line_aux_output_en, !k[0], "tx aux");
			chk(o_host_eq_en, 1, "tx host eq");
			chk(o_half_amp, 0, "tx splitter");
		end
		@(posedge i_clk_sys);
		rate_code <= SDIIO_RHD;
		for (int k = 0; k < 4; k++) begin
			@(posedge i_clk_sys);
			i_host_eq_strap_v <= sv[k];
			setp(1, 1, 1, 1, 0, 1);
			chk(o_heq_boost, bs[k], "strap boost");
			chk(o_heq_adaptive, 0, "strap fixed");
			chk(o_host_out_level, 3 - k, "out level");
		end
		@(posedge i_clk_sys);
		i_host_eq_strap_v <= 8'hb0;
		rate_code <= SDIIO_R3G;
		setp(1, 1, 1, 1, 0, 1);
		chk(o_heq_adaptive, 1, "3g adaptive");
		repeat (60) @(negedge i_clk_sys);
		chk(o_adapt_pick, 4'h5, "best pick");
		@(posedge i_clk_sys);
		i_heq_ovr <= 1;
		i_heq_ovr_boost <= 8'h5a;
		setp(1, 1, 1, 1, 0, 1);
		chk(o_heq_boost, 8'h5a, "override boost");
		chk(o_heq_adaptive, 0, "override mode");
		@(posedge i_clk_sys);
		i_heq_ovr <= 0;
		$display("transmit test done");
		setp(1, 1, 1, 1, 1, 0);
		chk(o_power, SDIIO_SAVE, "save");
		chk(o_detect_en, 1, "save detect");
		setp(1, 1, 1, 1, 1, 1);
		chk(o_power, SDIIO_RUN, "resume");
		setp(0, 1, 1, 1, 1, 1);
		chk(o_power, SDIIO_OFF, "forced off");
		chk(o_detect_en, 0, "off detect");
		@(posedge i_clk_sys);
		i_lock_pin_cd <= 1;
		setp(1, 1, 1, 1, 0, 1);
		chk({o_lock_n, o_signal_status}, 2'h1, "lock present");
		setp(1, 1, 1, 1, 0, 0);
		chk({o_lock_n, o_signal_status}, 2'h2, "lock absent");
		$display("power test done");
		for (int k = 1; k < 7; k++) begin
			@(posedge i_clk_sys);
			rate_code <= k[2:0];
			setp(1, 1, 1, 1, 0, 1);
			chk(o_reclock_en, k < 5, "reclock by rate");
		end
		$display("rate test done");
		give_verdict();
	end
endmodule
